// ---- hem_defines.svh ----
/*
  constants for the host/ec mailbox: ahb offsets, host indexes, fields,
  reset values. assumes inclusion by the mailbox top module and the testbench.
*/
//
// Summary of operation
// - all logic on one 48 mhz clock
// - system reset restores register defaults, not scratch memory contents
// - main rail reset clears index and data
// - serirq event when ec write flag enabled
// - smi when software source and enable set
// - smi also ors enabled ec write event
// - smi event drives host alert pin
// - host mailbox write interrupts ec if unmasked
// - ec writing ff clears host mailbox
// - host writing ff clears ec mailbox
`ifndef HEM_DEFINES_SVH
`define HEM_DEFINES_SVH

// ahb byte offsets
`define HEM_OFF_PORT_INDEX 12'h000
`define HEM_OFF_PORT_DATA 12'h004
`define HEM_OFF_H2E 12'h100
`define HEM_OFF_E2H 12'h104
`define HEM_OFF_SMI_SRC 12'h108
`define HEM_OFF_SMI_MASK 12'h10c
`define HEM_OFF_SCRATCH 12'h110
`define HEM_OFF_SCRATCH_END 12'h12c
`define HEM_OFF_IRQ_STAT 12'h130
`define HEM_OFF_IRQ_MASK 12'h134

// host indexes
`define HEM_IDX_H2E 8'h00
`define HEM_IDX_E2H 8'h01
`define HEM_IDX_SMI_SRC 8'h02
`define HEM_IDX_SMI_MASK 8'h03
`define HEM_IDX_SCRATCH 8'h10
`define HEM_IDX_SCRATCH_END 8'h2f

// fields of smi source / mask: bit 0 = ec write, bits 7:1 software
`define HEM_BIT_EC_TO_HOST_WRITTEN 0
`define HEM_CLEAR_CODE 8'hff
`define HEM_RESET_BYTE 8'h00
`define HEM_SCRATCH_WORDS 8
`define HEM_CLK_MHZ 48

`endif

// ---- hem_pkg.sv ----
/*
  types for the host/ec mailbox. assumes hem_defines.svh alongside.
*/
package hem_pkg;
  typedef struct packed {
    logic [7:0] port_index;
    logic [7:0] port_data;
    logic [7:0] h2e;
    logic [7:0] e2h;
    logic [7:0] smi_src;
    logic [7:0] smi_mask;
    logic irq_stat;
    logic irq_mask;
  } hem_regs_t;

  typedef struct packed {
    logic pend;
    logic wr;
    logic [11:0] addr;
  } hem_ahb_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hem_hreq_t;

  typedef struct packed {
    hem_regs_t r;
    hem_ahb_t a;
    logic [31:0] rdata;
    logic alert_n;
    logic serirq;
    logic irq;
    logic [1:0] vcc_sync;
    logic vcc_prev;
  } hem_state_t;
endpackage

// ---- hem_scratch_mem.sv ----
/*
  32-byte scratch memory, eight words with byte enables, registered read.
  assumes one clock and synchronous access from the mailbox top.
*/
`timescale 1ns/1ps
module hem_scratch_mem (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [3:0] i_be,
  input wire logic [2:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:7];

  // no reset: contents are scratch, read port registered
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        for (int b = 0; b < 4; b++) begin
          if (i_be[b]) begin
            mem[i_addr][8*b +: 8] <= i_wdata[8*b +: 8];
          end
        end
      end
      o_rdata <= mem[i_addr];
    end
  end
endmodule // hem_scratch_mem

// ---- hem_mailbox.sv ----
/*
  host/ec mailbox: ahb-lite slave for the ec, byte host port, smi alert,
  serirq event and ec interrupt. assumes host strobes are synchronous.
*/
`timescale 1ns/1ps
`include "hem_defines.svh"
module hem_mailbox
  import hem_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic I_VCC_RESETN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic I_HOST_WR,
  input wire logic I_HOST_RD,
  input wire logic I_HOST_ADDR,
  input wire logic [7:0] I_HOST_WDATA,
  output logic [7:0] O_HOST_RDATA,
  output logic O_SERIRQ_EVT,
  output logic O_SMI_EVT,
  output logic O_HOST_ALERT_N,
  output logic O_HOST_ALERT_OE,
  output logic O_IRQ
);
  hem_state_t s;
  hem_state_t next_s;
  logic [7:0] host_rbyte;
  logic host_rd_q;
  logic [31:0] mem_rdata;
  logic mem_we;
  logic [2:0] mem_addr;
  logic [3:0] mem_be;
  logic [31:0] mem_wdata;
  logic [7:0] hrd_byte;
  hem_hreq_t hq;

  hem_scratch_mem u_mem (
    .i_clk(I_CLK),
    .i_ce(I_CE),
    .i_we(mem_we),
    .i_be(mem_be),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // host request decode
  always_comb begin
    hq.wr = I_HOST_WR;
    hq.rd = I_HOST_RD;
    hq.sel = I_HOST_ADDR;
    hq.wdata = I_HOST_WDATA;
    hq.addr = s.r.port_index;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic ahb_addr_ok;
    logic ahb_dwr;
    logic host_data_wr;
    logic host_data_rd;
    logic [7:0] wb;
    logic smi;
    logic h2e_set;
    ahb_addr_ok = 1'b0;
    ahb_dwr = 1'b0;
    host_data_wr = 1'b0;
    host_data_rd = 1'b0;
    wb = I_HWDATA[7:0];
    smi = 1'b0;
    h2e_set = 1'b0;
    next_s = s;
    mem_we = 1'b0;
    mem_be = 4'h0;
    mem_addr = 3'h0;
    mem_wdata = 32'h0000_0000;
    hrd_byte = 8'h00;

    // ahb data phase of a write
    ahb_dwr = s.a.pend && s.a.wr;
    if (ahb_dwr) begin
      case (s.a.addr)
        `HEM_OFF_PORT_INDEX: next_s.r.port_index = wb;
        `HEM_OFF_PORT_DATA: next_s.r.port_data = wb;
        `HEM_OFF_H2E: begin
          // ec ff write acknowledges host command
          if (wb == `HEM_CLEAR_CODE) begin
            next_s.r.h2e = `HEM_RESET_BYTE;
          end else begin
            next_s.r.h2e = wb;
          end
        end
        `HEM_OFF_E2H: next_s.r.e2h = wb;
        `HEM_OFF_SMI_SRC: next_s.r.smi_src = wb;
        `HEM_OFF_SMI_MASK: next_s.r.smi_mask = wb;
        `HEM_OFF_IRQ_STAT: begin
          if (I_HWDATA[0]) begin
            next_s.r.irq_stat = 1'b0;
          end
        end
        `HEM_OFF_IRQ_MASK: next_s.r.irq_mask = I_HWDATA[0];
        default: begin
        end
      endcase
      if (s.a.addr >= `HEM_OFF_SCRATCH &&
          s.a.addr <= `HEM_OFF_SCRATCH_END) begin
        mem_we = 1'b1;
        mem_be = 4'hf;
        mem_addr = 3'(s.a.addr[4:2] - 3'h4);
        mem_wdata = I_HWDATA;
      end
    end

    // host port: index then data
    host_data_wr = hq.wr && hq.sel;
    host_data_rd = hq.rd && hq.sel;
    if (hq.wr && !hq.sel) begin
      next_s.r.port_index = hq.wdata;
    end
    if (host_data_wr) begin
      next_s.r.port_data = hq.wdata;
      case (hq.addr)
        `HEM_IDX_H2E: begin
          next_s.r.h2e = hq.wdata;
          h2e_set = 1'b1;
        end
        `HEM_IDX_E2H: begin
          if (hq.wdata == `HEM_CLEAR_CODE) begin
            next_s.r.e2h = `HEM_RESET_BYTE;
          end else begin
            next_s.r.e2h = hq.wdata;
          end
        end
        `HEM_IDX_SMI_SRC: next_s.r.smi_src = hq.wdata;
        `HEM_IDX_SMI_MASK: next_s.r.smi_mask = hq.wdata;
        default: begin
        end
      endcase
      if (!mem_we && hq.addr >= `HEM_IDX_SCRATCH &&
          hq.addr <= `HEM_IDX_SCRATCH_END) begin
        mem_we = 1'b1;
        // host index 10h is scratch word 0, same word as ec offset 110h
        mem_addr = 3'(hq.addr[4:2] - 3'h4);
        mem_be = 4'h1 << hq.addr[1:0];
        mem_wdata = {4{hq.wdata}};
      end
    end
    if (!mem_we && host_data_rd) begin
      mem_addr = 3'(hq.addr[4:2] - 3'h4);
    end else if (!mem_we && s.a.pend == 1'b0 && I_HSEL && I_HREADY) begin
      mem_addr = 3'(I_HADDR[4:2] - 3'h4);
    end

    // sticky ec interrupt: set beats clear
    if (h2e_set) begin
      next_s.r.irq_stat = 1'b1;
    end
    next_s.irq = next_s.r.irq_stat && next_s.r.irq_mask;

    // ec write flag: set while ec->host mailbox nonzero
    next_s.r.smi_src[`HEM_BIT_EC_TO_HOST_WRITTEN] = (next_s.r.e2h != 8'h00);
    next_s.serirq = next_s.r.smi_src[`HEM_BIT_EC_TO_HOST_WRITTEN] &&
                    next_s.r.smi_mask[`HEM_BIT_EC_TO_HOST_WRITTEN];
    smi = |(next_s.r.smi_src & next_s.r.smi_mask);
    next_s.alert_n = !smi;

    // ahb address phase capture
    if (I_HREADY) begin
      next_s.a.pend = I_HSEL && I_HTRANS[1];
      next_s.a.wr = I_HWRITE;
      next_s.a.addr = I_HADDR[11:0];
    end
    if (s.a.pend && !s.a.wr) begin
      next_s.rdata = 32'h0000_0000;
    end

    // main rail reset: two-flop sync then clear on release
    next_s.vcc_sync = {s.vcc_sync[0], I_VCC_RESETN};
    next_s.vcc_prev = s.vcc_sync[1];
    if (s.vcc_sync[1] && !s.vcc_prev) begin
      next_s.r.port_index = `HEM_RESET_BYTE;
      next_s.r.port_data = `HEM_RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read muxes
  always_comb begin
    case (s.a.addr)
      `HEM_OFF_PORT_INDEX: O_HRDATA = {24'h0, s.r.port_index};
      `HEM_OFF_PORT_DATA: O_HRDATA = {24'h0, s.r.port_data};
      `HEM_OFF_H2E: O_HRDATA = {24'h0, s.r.h2e};
      `HEM_OFF_E2H: O_HRDATA = {24'h0, s.r.e2h};
      `HEM_OFF_SMI_SRC: O_HRDATA = {24'h0, s.r.smi_src};
      `HEM_OFF_SMI_MASK: O_HRDATA = {24'h0, s.r.smi_mask};
      `HEM_OFF_IRQ_STAT: O_HRDATA = {31'h0, s.r.irq_stat};
      `HEM_OFF_IRQ_MASK: O_HRDATA = {31'h0, s.r.irq_mask};
      default: begin
        if (s.a.addr >= `HEM_OFF_SCRATCH &&
            s.a.addr <= `HEM_OFF_SCRATCH_END) begin
          O_HRDATA = mem_rdata;
        end else begin
          O_HRDATA = 32'h0000_0000;
        end
      end
    endcase
  end

  always_comb begin
    case (s.r.port_index)
      `HEM_IDX_H2E: host_rbyte = s.r.h2e;
      `HEM_IDX_E2H: host_rbyte = s.r.e2h;
      `HEM_IDX_SMI_SRC: host_rbyte = s.r.smi_src;
      `HEM_IDX_SMI_MASK: host_rbyte = s.r.smi_mask;
      default: host_rbyte = mem_rdata[8*s.r.port_index[1:0] +: 8];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      s <= '0;
      s.alert_n <= 1'b1;
      host_rd_q <= 1'b0;
      O_HOST_RDATA <= 8'h00;
    end else if (I_CE) begin
      s <= next_s;
      host_rd_q <= I_HOST_RD;
      // scratch byte arrives one cycle after read strobe
      if (host_rd_q) begin
        O_HOST_RDATA <= I_HOST_ADDR ? host_rbyte : s.r.port_index;
      end
    end
  end

  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_SERIRQ_EVT = s.serirq;
  assign O_SMI_EVT = !s.alert_n;
  assign O_HOST_ALERT_N = 1'b0;
  assign O_HOST_ALERT_OE = !s.alert_n; // open drain pull low
  assign O_IRQ = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_alert_follows_smi: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) I_CE |=> O_SMI_EVT == O_HOST_ALERT_OE)
    else $error("alert enable differs from smi");
  a_serirq_cause: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) O_SERIRQ_EVT |-> s.r.e2h != 8'h00
      && s.r.smi_mask[0]) else $error("serirq without cause");
  a_smi_cause: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) O_SMI_EVT |-> |(s.r.smi_src & s.r.smi_mask))
    else $error("smi without enabled source");
  a_smi_or_wr: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) O_SERIRQ_EVT |-> O_SMI_EVT)
    else $error("ec write event not in smi");
  a_host_irq_set: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) I_CE && I_HOST_WR && I_HOST_ADDR &&
      s.r.port_index == 8'h00 |=> s.r.irq_stat)
    else $error("host mailbox write lost");
  a_h2e_clear: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) I_CE && s.a.pend && s.a.wr &&
      s.a.addr == 12'h100 && I_HWDATA[7:0] == 8'hff && !I_HOST_WR
      |=> s.r.h2e == 8'h00) else $error("ff write did not clear");
  a_e2h_clear: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) I_CE && I_HOST_WR && I_HOST_ADDR &&
      s.r.port_index == 8'h01 && I_HOST_WDATA == 8'hff && !s.a.pend
      |=> s.r.e2h == 8'h00) else $error("host ff did not clear");
  a_vcc_index_clr: assert property (@(posedge I_CLK)
    disable iff (!I_RESETN) I_CE && s.vcc_sync[1] && !s.vcc_prev
      |=> s.r.port_index == 8'h00) else $error("index kept over rail");
  c_smi: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    $fell(O_HOST_ALERT_N ^ O_HOST_ALERT_OE));
  c_irq: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    $rose(O_IRQ));
  c_serirq: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    $rose(O_SERIRQ_EVT));
endmodule // hem_mailbox

// ---- hem_host_model.sv ----
/*
  host chipset model: byte strobes on the index/data port, pull-up on the
  open-drain alert pin. assumes the bench calls its tasks by hierarchy.
*/
`timescale 1ns/1ps
module hem_host_model (
  input wire logic i_clk,
  input wire logic i_alert_n,
  input wire logic i_alert_oe,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_addr,
  output logic [7:0] o_wdata,
  output logic o_alert_wire
);
  // pin is only pulled low while enabled, pull-up otherwise
  assign o_alert_wire = i_alert_oe ? i_alert_n : 1'b1;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 1'b0;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // released data byte is inverted so a stale value never passes
  task automatic put(input logic a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic get(input logic a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    repeat (2) @(posedge i_clk);
    d = i_rdata;
  endtask
  // index always goes first, then the data port
  task automatic idx_get(input logic [7:0] i, output logic [7:0] d);
    put(1'b0, i);
    get(1'b1, d);
  endtask
endmodule // hem_host_model

// ---- testbench.sv ----
/*
  self-checking bench for hem_mailbox: ahb-lite ec master, host model.
  assumes the design's defines header and the host model file.
*/
`timescale 1ns/1ps
`include "hem_defines.svh"
module testbench;
  import hem_pkg::*;
  logic I_CLK, I_RESETN, I_CE, I_VCC_RESETN, I_HSEL, I_HWRITE;
  logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, obs, r;
  logic [1:0] I_HTRANS;
  logic [2:0] I_HSIZE;
  logic O_HREADYOUT, O_HRESP, hwr, hrd, ha, irq, serirq, smi, al_n, al_oe;
  logic alert;
  logic [7:0] hwd, hrdata, d, m, b;
  logic [31:0] w;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int tests_run = 0;
  int unsigned s;
  event ev;
  always #2 I_CLK = ~I_CLK;
  hem_mailbox hem_mailbox_inst (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .I_CE(I_CE), .I_VCC_RESETN(I_VCC_RESETN), .I_HSEL(I_HSEL),
    .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(O_HREADYOUT),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_HRDATA(O_HRDATA),
    .I_HOST_WR(hwr), .I_HOST_RD(hrd), .I_HOST_ADDR(ha),
    .I_HOST_WDATA(hwd), .O_HOST_RDATA(hrdata), .O_SERIRQ_EVT(serirq),
    .O_SMI_EVT(smi), .O_HOST_ALERT_N(al_n), .O_HOST_ALERT_OE(al_oe),
    .O_IRQ(irq));
  hem_host_model hem_host_model_inst (.i_clk(I_CLK), .i_alert_n(al_n),
    .i_alert_oe(al_oe), .i_rdata(hrdata), .o_wr(hwr), .o_rd(hrd),
    .o_addr(ha), .o_wdata(hwd), .o_alert_wire(alert));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // monitor takes the oldest note whenever a result is posted
  always @(ev) begin
    tests_run++;
    if (exp_q.size() == 0 || obs !== exp_q[0]) begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, obs, exp_q[0]);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] o);
    exp_q.push_back(e);
    obs = o;
    ->ev;
    #1;
  endtask
  // address phase held until hready, then data phase until hready
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge I_CLK);
    I_HSEL <= 1'b1;
    I_HTRANS <= 2'h2;
    I_HADDR <= {20'h00000, a};
    I_HWRITE <= w;
    do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
    I_HTRANS <= 2'h0;
    I_HWDATA <= wd;
    do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
    rd = O_HRDATA;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h00000000, r);
    chk(e, r);
  endtask
  task automatic settle;
    repeat (4) @(posedge I_CLK);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial begin
    {I_HSEL, I_HTRANS, I_HWRITE, I_HADDR, I_HWDATA} = '0;
    {I_CLK, I_RESETN, I_VCC_RESETN} = '0;
    I_HSIZE = 3'h2;
    I_CE = 1'b1;
    s = $urandom(33333);
    repeat (6) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    I_VCC_RESETN <= 1'b1;
    rdc(`HEM_OFF_H2E, 0);
    rdc(`HEM_OFF_SMI_MASK, 0);
    rdc(`HEM_OFF_IRQ_STAT, 0);
    rdc(12'h200, 0);
    d = 8'($urandom);
    wr(`HEM_OFF_IRQ_MASK, 1);
    hem_host_model_inst.put(1'b0, `HEM_IDX_H2E);
    hem_host_model_inst.put(1'b1, d);
    rdc(`HEM_OFF_H2E, {24'h000000, d});
    settle;
    chk(1, irq);
    wr(`HEM_OFF_IRQ_STAT, 1);
    settle;
    chk(0, irq);
    wr(`HEM_OFF_H2E, 32'h000000ff);
    rdc(`HEM_OFF_H2E, 0);
    d = 8'($urandom_range(1, 254));
    wr(`HEM_OFF_SMI_MASK, 1);
    wr(`HEM_OFF_E2H, {24'h000000, d});
    settle;
    chk(1, serirq);
    chk(1, smi);
    chk(0, alert);
    hem_host_model_inst.idx_get(`HEM_IDX_E2H, b);
    chk(d, b);
    hem_host_model_inst.put(1'b1, 8'hff);
    rdc(`HEM_OFF_E2H, 0);
    settle;
    chk(0, serirq);
    chk(1, alert);
    for (int k = 1; k < 8; k++) begin
      m = 8'($urandom);
      wr(`HEM_OFF_SMI_MASK, {24'h000000, m});
      wr(`HEM_OFF_SMI_SRC, 32'h1 << k);
      settle;
      chk(m[k], smi);
      chk(!m[k], alert);
    end
    // scratch is shared: ec word writes seen by host bytes and back
    w = $urandom;
    wr(`HEM_OFF_SCRATCH, w);
    hem_host_model_inst.idx_get(`HEM_IDX_SCRATCH | 8'h01, b);
    chk({24'h000000, w[15:8]}, {24'h000000, b});
    w = $urandom;
    d = 8'($urandom);
    wr(`HEM_OFF_SCRATCH_END, w);
    hem_host_model_inst.put(1'b0, `HEM_IDX_SCRATCH_END);
    hem_host_model_inst.put(1'b1, d);
    rdc(`HEM_OFF_SCRATCH_END, {d, w[23:0]});
    hem_host_model_inst.put(1'b0, `HEM_IDX_SMI_MASK);
    rdc(`HEM_OFF_PORT_INDEX, 32'h3);
    I_VCC_RESETN <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_VCC_RESETN <= 1'b1;
    repeat (6) @(posedge I_CLK);
    rdc(`HEM_OFF_PORT_INDEX, 0);
    rdc(`HEM_OFF_PORT_DATA, 0);
    rdc(`HEM_OFF_SMI_MASK, {24'h000000, m});
    // second system reset mid-run, with a source still pending
    @(posedge I_CLK);
    I_RESETN <= 1'b0;
    repeat (2) @(posedge I_CLK);
    chk(0, smi);
    I_RESETN <= 1'b1;
    rdc(`HEM_OFF_SMI_MASK, 0);
    rdc(`HEM_OFF_SMI_SRC, 0);
    end_of_test;
  end
endmodule // testbench
